// ---- hdl/sac_pkg.sv ----
// Constants and types shared by the supply and ADC configuration register bank.
package sac_pkg;

    // Clock rate and logic-rail turn-on delay step.
    localparam int CLK_HZ          = 20_000_000;
    localparam int TON_STEP_US     = 200;
    localparam int TON_STEP_CYCLES = (CLK_HZ / 1_000_000) * TON_STEP_US;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_ADC_STATUS   = 8'h05;
    localparam logic [7:0] IDX_SUPPLY_SETUP = 8'h11;
    localparam logic [7:0] IDX_ADC_SETUP    = 8'h12;

    // Reset values.
    localparam logic [15:0] SUPPLY_SETUP_RST = 16'h6000;
    localparam logic [15:0] ADC_SETUP_RST    = 16'h0000;
    localparam logic [15:0] ADC_STATUS_RST   = 16'h0000;

    // Supply setup field positions.
    localparam int SUP_BUCK_RATE_POS = 12;
    localparam int SUP_TON_DELAY_LSB = 13;
    localparam int SUP_PRECHARGE_POS = 15;

    // Housekeeping ADC setup field positions.
    localparam int ADC_REQ_POS       = 0;
    localparam int ADC_SEL_LSB       = 1;
    localparam int ADC_FILT_EN_POS   = 3;
    localparam int ADC_DEPTH_LSB     = 4;

    // ADC status field positions.
    localparam int STS_READY_POS     = 0;
    localparam int STS_VALUE_LSB     = 1;

    // On-demand input select codes.
    localparam logic [1:0] SEL_DIGITAL_AREA_CURRENT = 2'h0;
    localparam logic [1:0] SEL_LOGIC_SUPPLY_RAIL    = 2'h1;
    localparam logic [1:0] SEL_BRIDGE_SUPPLY_RAIL   = 2'h2;
    localparam logic [1:0] SEL_RESERVED             = 2'h3;

    // Smallest moving-average window; each depth code step doubles it.
    localparam logic [6:0] AVG_MIN_SAMPLES = 7'h08;

    // AHB-Lite encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE    = 3'h0;
    localparam logic [2:0] HSIZE_HALF    = 3'h1;
    localparam logic       HRESP_OKAY    = 1'h0;

    // Start-up sequencer states.
    typedef enum logic [2:0] {
        SAC_WAIT_UV = 3'b001,
        SAC_DELAY   = 3'b010,
        SAC_RAIL_ON = 3'b100
    } sac_state_t;

endpackage

// ---- hdl/sac_regs.sv ----
// Supply and housekeeping ADC configuration registers behind an AHB-Lite slave.
//
// How it works
// - Partial ADC setup write defaults other fields.
// - Request bit injects one conversion unless select is reserved; reads zero.
// - Two-bit select picks current, logic, bridge.
// - Filter enable write turns filtering on.
// - Depth code selects 8 to 64 samples.
// - Buck rate bit selects 500k or 1M.
// - Rail turns on after configured delay.
// - Precharge bit enables pump precharge at start.
// - Supply setup resets to 6000; 11:10 reserved.
// - Conversion done sets ready and result.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps

module sac_regs #(
    parameter int TON_STEP_CYCLES = sac_pkg::TON_STEP_CYCLES
) (
    input  wire logic        clk,                // Block clock, 20 MHz.
    input  wire logic        srst,               // Synchronous reset, active high.
    input  wire logic        hsel,               // AHB slave select.
    input  wire logic [31:0] haddr,              // AHB address.
    input  wire logic [1:0]  htrans,             // AHB transfer type.
    input  wire logic        hwrite,             // AHB write when high.
    input  wire logic [2:0]  hsize,              // AHB transfer size.
    input  wire logic [31:0] hwdata,             // AHB write data.
    input  wire logic        hready,             // AHB bus ready.
    output logic      [31:0] hrdata,             // AHB read data.
    output logic             hreadyout,          // AHB slave ready.
    output logic             hresp,              // AHB response, always OKAY.
    input  wire logic        undervoltageRelease,// Bridge supply out of undervoltage.
    input  wire logic        adcDone,            // On-demand conversion finished pulse.
    input  wire logic [6:0]  adcResult,          // On-demand conversion result.
    output logic             logicRailEnable,    // Logic supply rail enable.
    output logic             pumpPrecharge,      // Charge pump precharge active.
    output logic             buckRateSelect,     // Buck rate: 0 low, 1 high.
    output logic             onDemandRequest,    // One-cycle conversion request.
    output logic      [1:0]  onDemandSelect,     // On-demand input select.
    output logic             filterEnablePulse,  // One-cycle filter enable pulse.
    output logic             onDemandFilterOn,   // On-demand filtering switched on.
    output logic      [1:0]  averageDepth,       // Moving-average depth code.
    output logic      [6:0]  averageSamples      // Moving-average window in samples.
);

    typedef struct packed {
        sac_pkg::sac_state_t state;
        logic [15:0]         delayCnt;
        logic [15:0]         delayTarget;
        logic                dataPhase;
        logic                dpWrite;
        logic [7:0]          dpIdx;
        logic [3:0]          dpLanes;
        logic                precharge;
        logic [1:0]          tonDelay;
        logic                buckRate;
        logic [1:0]          adcSel;
        logic [1:0]          adcDepth;
        logic                odReady;
        logic [6:0]          odValue;
        logic                odFilterOn;
        logic                odReqPulse;
        logic                filtPulse;
        logic                railOn;
        logic                pumpOn;
        logic [31:0]         rdata;
        logic                readyOut;
        logic                respBit;
        logic [6:0]          avgSamples;
    } sac_regs_t;

    sac_regs_t stateReg;
    sac_regs_t stateNext;

    // Byte lanes touched by an access of the given size and address.
    function automatic logic [3:0] laneMask(input logic [2:0] size, input logic [1:0] addr);
        logic [3:0] mask;
        mask = 4'hf;
        if (size == sac_pkg::HSIZE_BYTE) begin
            mask = 4'h1 << addr;
        end else if (size == sac_pkg::HSIZE_HALF) begin
            mask = addr[1] ? 4'hc : 4'h3;
        end
        return mask;
    endfunction

    // Delay in cycles for a turn-on delay code.
    function automatic logic [15:0] delayCycles(input logic [1:0] code);
        logic [17:0] steps;
        steps = {16'h0000, code} + 18'h0_0001;
        return 16'(steps * 18'(TON_STEP_CYCLES));
    endfunction

    // Read value of a register index from a given state.
    function automatic logic [31:0] readWord(input logic [7:0] idx, input sac_regs_t s);
        logic [15:0] val;
        val = 16'h0000;
        unique case (idx)
            sac_pkg::IDX_SUPPLY_SETUP: begin
                val[sac_pkg::SUP_PRECHARGE_POS]                       = s.precharge;
                val[sac_pkg::SUP_TON_DELAY_LSB +: 2]                  = s.tonDelay;
                val[sac_pkg::SUP_BUCK_RATE_POS]                       = s.buckRate;
            end
            sac_pkg::IDX_ADC_SETUP: begin
                // Request and filter enable bits always read back as zero.
                val[sac_pkg::ADC_SEL_LSB +: 2]                        = s.adcSel;
                val[sac_pkg::ADC_DEPTH_LSB +: 2]                      = s.adcDepth;
            end
            sac_pkg::IDX_ADC_STATUS: begin
                val[sac_pkg::STS_READY_POS]                           = s.odReady;
                val[sac_pkg::STS_VALUE_LSB +: 7]                      = s.odValue;
            end
            default: begin
                val = 16'h0000;
            end
        endcase
        return {16'h0000, val};
    endfunction

    always_comb begin
        logic        addrPhase;
        logic        wrSupply;
        logic        wrAdc;
        logic        rdStatus;
        logic [15:0] merged;
        logic [15:0] oldVal;
        logic [15:0] wdata;
        logic [15:0] lanes16;

        stateNext = stateReg;
        merged    = 16'h0000;
        oldVal    = 16'h0000;
        addrPhase = hsel && hready && (htrans == sac_pkg::HTRANS_NONSEQ || htrans[1]);
        wdata     = hwdata[15:0];
        lanes16   = {{8{stateReg.dpLanes[1]}}, {8{stateReg.dpLanes[0]}}};
        wrSupply  = stateReg.dataPhase && stateReg.dpWrite
                    && stateReg.dpIdx == sac_pkg::IDX_SUPPLY_SETUP;
        wrAdc     = stateReg.dataPhase && stateReg.dpWrite
                    && stateReg.dpIdx == sac_pkg::IDX_ADC_SETUP;
        rdStatus  = addrPhase && !hwrite && haddr[9:2] == sac_pkg::IDX_ADC_STATUS;

        stateNext.odReqPulse = 1'b0;
        stateNext.filtPulse  = 1'b0;
        stateNext.readyOut   = 1'b1;
        stateNext.respBit    = sac_pkg::HRESP_OKAY;

        // Bus address phase is captured for the following data phase.
        stateNext.dataPhase = addrPhase;
        stateNext.dpWrite   = addrPhase && hwrite;
        stateNext.dpIdx     = addrPhase ? haddr[9:2] : stateReg.dpIdx;
        stateNext.dpLanes   = addrPhase ? laneMask(hsize, haddr[1:0]) : stateReg.dpLanes;

        // supply reset layout: reserved bits are not stored.
        if (wrSupply) begin
            oldVal = 16'(readWord(sac_pkg::IDX_SUPPLY_SETUP, stateReg));
            merged = (wdata & lanes16) | (oldVal & ~lanes16);
            stateNext.precharge = merged[sac_pkg::SUP_PRECHARGE_POS];
            stateNext.tonDelay  = merged[sac_pkg::SUP_TON_DELAY_LSB +: 2];
            stateNext.buckRate  = merged[sac_pkg::SUP_BUCK_RATE_POS];
        end

        // partial write: lanes not written take the reset value.
        if (wrAdc) begin
            merged = (wdata & lanes16) | (sac_pkg::ADC_SETUP_RST & ~lanes16);
            stateNext.adcSel   = merged[sac_pkg::ADC_SEL_LSB +: 2];
            stateNext.adcDepth = merged[sac_pkg::ADC_DEPTH_LSB +: 2];
            // request pulse: reserved select code starts nothing.
            stateNext.odReqPulse = merged[sac_pkg::ADC_REQ_POS]
                                   && merged[sac_pkg::ADC_SEL_LSB +: 2] != sac_pkg::SEL_RESERVED;
            // pulses only: a zero write never cancels.
            stateNext.filtPulse  = merged[sac_pkg::ADC_FILT_EN_POS];
        end

        // filter enable is sticky once switched on.
        if (stateReg.filtPulse) begin
            stateNext.odFilterOn = 1'b1;
        end

        // Read data sees any write completing in this same cycle.
        stateNext.rdata = (addrPhase && !hwrite) ? readWord(haddr[9:2], stateNext) : 32'h0000_0000;

        // ready and result: a completion wins over the read clear.
        if (rdStatus) begin
            stateNext.odReady = 1'b0;
        end
        if (adcDone) begin
            stateNext.odReady = 1'b1;
            stateNext.odValue = adcResult;
        end

        // start-up delay counted from undervoltage release.
        unique case (stateReg.state)
            sac_pkg::SAC_WAIT_UV: begin
                stateNext.delayCnt = 16'h0000;
                stateNext.railOn   = 1'b0;
                if (undervoltageRelease) begin
                    stateNext.state       = sac_pkg::SAC_DELAY;
                    stateNext.delayTarget = delayCycles(stateReg.tonDelay);
                end
            end
            sac_pkg::SAC_DELAY: begin
                stateNext.delayCnt = stateReg.delayCnt + 16'h0001;
                if (!undervoltageRelease) begin
                    stateNext.state = sac_pkg::SAC_WAIT_UV;
                end else if (stateReg.delayCnt + 16'h0001 >= stateReg.delayTarget) begin
                    stateNext.state  = sac_pkg::SAC_RAIL_ON;
                    stateNext.railOn = 1'b1;
                end
            end
            sac_pkg::SAC_RAIL_ON: begin
                stateNext.railOn = 1'b1;
                if (!undervoltageRelease) begin
                    stateNext.state  = sac_pkg::SAC_WAIT_UV;
                    stateNext.railOn = 1'b0;
                end
            end
            default: begin
                stateNext.state  = sac_pkg::SAC_WAIT_UV;
                stateNext.railOn = 1'b0;
            end
        endcase

        // precharge only while the start-up delay runs.
        stateNext.pumpOn = (stateNext.state == sac_pkg::SAC_DELAY) && stateNext.precharge;

        if (srst) begin
            stateNext             = '0;
            stateNext.state       = sac_pkg::SAC_WAIT_UV;
            stateNext.readyOut    = 1'b1;
            stateNext.precharge   = sac_pkg::SUPPLY_SETUP_RST[sac_pkg::SUP_PRECHARGE_POS];
            stateNext.tonDelay    = sac_pkg::SUPPLY_SETUP_RST[sac_pkg::SUP_TON_DELAY_LSB +: 2];
            stateNext.buckRate    = sac_pkg::SUPPLY_SETUP_RST[sac_pkg::SUP_BUCK_RATE_POS];
            stateNext.adcSel      = sac_pkg::ADC_SETUP_RST[sac_pkg::ADC_SEL_LSB +: 2];
            stateNext.adcDepth    = sac_pkg::ADC_SETUP_RST[sac_pkg::ADC_DEPTH_LSB +: 2];
            stateNext.odReady     = sac_pkg::ADC_STATUS_RST[sac_pkg::STS_READY_POS];
            stateNext.odValue     = sac_pkg::ADC_STATUS_RST[sac_pkg::STS_VALUE_LSB +: 7];
        end

        stateNext.avgSamples = sac_pkg::AVG_MIN_SAMPLES << stateNext.adcDepth;
    end

    always_ff @(posedge clk) begin
        stateReg <= stateNext;
    end

    assign hrdata            = stateReg.rdata;
    assign hreadyout         = stateReg.readyOut;
    assign hresp             = stateReg.respBit;
    assign logicRailEnable   = stateReg.railOn;
    assign pumpPrecharge     = stateReg.pumpOn;
    // buck rate straight from its setup bit.
    assign buckRateSelect    = stateReg.buckRate;
    // request and its input leave together.
    assign onDemandRequest   = stateReg.odReqPulse;
    // input select code driven to the converter.
    assign onDemandSelect    = stateReg.adcSel;
    assign filterEnablePulse = stateReg.filtPulse;
    assign onDemandFilterOn  = stateReg.odFilterOn;
    // depth code and its window size.
    assign averageDepth      = stateReg.adcDepth;
    assign averageSamples    = stateReg.avgSamples;

endmodule

// ---- test/sac_regs_checker.sv ----
// Concurrent checks on the supply and ADC configuration register bank ports.
`timescale 1ns/1ps

module sac_regs_checker #(
    parameter int TON_STEP_CYCLES = 4
) (
    input wire logic        clk,                 // Block clock.
    input wire logic        srst,                // Synchronous reset.
    input wire logic        hsel,                // AHB select.
    input wire logic [31:0] haddr,               // AHB address.
    input wire logic [1:0]  htrans,              // AHB transfer type.
    input wire logic        hwrite,              // AHB write.
    input wire logic [2:0]  hsize,               // AHB size.
    input wire logic [31:0] hwdata,              // AHB write data.
    input wire logic        hready,              // AHB ready.
    input wire logic [31:0] hrdata,              // AHB read data.
    input wire logic        hreadyout,           // AHB slave ready.
    input wire logic        hresp,               // AHB response.
    input wire logic        undervoltageRelease, // Bridge supply good.
    input wire logic        adcDone,             // Conversion done.
    input wire logic [6:0]  adcResult,           // Conversion result.
    input wire logic        logicRailEnable,     // Logic rail on.
    input wire logic        pumpPrecharge,       // Precharge active.
    input wire logic        buckRateSelect,      // Buck rate.
    input wire logic        onDemandRequest,     // Request pulse.
    input wire logic [1:0]  onDemandSelect,      // Input select.
    input wire logic        filterEnablePulse,   // Filter pulse.
    input wire logic        onDemandFilterOn,    // Filter on.
    input wire logic [1:0]  averageDepth,        // Depth code.
    input wire logic [6:0]  averageSamples       // Window size.
);
    logic        wrPhase_reg;
    logic        rdPhase_reg;
    logic        reqCause_reg;
    logic        filtCause_reg;
    logic [7:0]  idx_reg;
    logic [15:0] uvCnt_reg;

    // Tracks AHB data phases and how long the bridge supply has been good.
    always_ff @(posedge clk) begin
        wrPhase_reg   <= !srst && hsel && hready && htrans[1] && hwrite;
        rdPhase_reg   <= !srst && hsel && hready && htrans[1] && !hwrite;
        idx_reg       <= haddr[9:2];
        reqCause_reg  <= wrPhase_reg && idx_reg == sac_pkg::IDX_ADC_SETUP && hwdata[0];
        filtCause_reg <= wrPhase_reg && idx_reg == sac_pkg::IDX_ADC_SETUP && hwdata[3];
        uvCnt_reg     <= (srst || !undervoltageRelease) ? 16'h0000 : uvCnt_reg + 16'h0001;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    samples_map_a: assert property (averageSamples == (7'h08 << averageDepth))
        else $error("average window does not match depth code");
    request_cause_a: assert property (onDemandRequest |-> reqCause_reg)
        else $error("request pulse without a write of one");
    request_made_a: assert property (reqCause_reg |-> onDemandRequest == (onDemandSelect != 2'h3))
        else $error("request pulse wrong for select code");
    filter_pulse_a: assert property (filterEnablePulse == filtCause_reg)
        else $error("filter pulse not tied to its write");
    filter_sticky_a: assert property (filterEnablePulse |=> onDemandFilterOn)
        else $error("filtering not switched on");
    filter_hold_a: assert property ($past(onDemandFilterOn) && !$past(srst) |-> onDemandFilterOn)
        else $error("filtering switched off without reset");
    adc_read_a: assert property (rdPhase_reg && idx_reg == sac_pkg::IDX_ADC_SETUP
        |-> hrdata[0] == 1'b0 && hrdata[3] == 1'b0)
        else $error("write-only ADC bits read nonzero");
    supply_read_a: assert property (rdPhase_reg && idx_reg == sac_pkg::IDX_SUPPLY_SETUP
        |-> hrdata[11:10] == 2'b00)
        else $error("reserved supply bits read nonzero");
    rail_delay_a: assert property (logicRailEnable |-> uvCnt_reg > TON_STEP_CYCLES)
        else $error("logic rail on before the delay");
    rail_drop_a: assert property (!undervoltageRelease |=> !logicRailEnable)
        else $error("logic rail stays on after undervoltage");
    precharge_a: assert property (pumpPrecharge |-> !logicRailEnable)
        else $error("precharge while logic rail is on");
endmodule

bind sac_regs sac_regs_checker #(.TON_STEP_CYCLES(TON_STEP_CYCLES)) u_sac_regs_checker (.clk, .srst,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .undervoltageRelease, .adcDone, .adcResult, .logicRailEnable, .pumpPrecharge,
    .buckRateSelect, .onDemandRequest, .onDemandSelect, .filterEnablePulse, .onDemandFilterOn,
    .averageDepth, .averageSamples);

// ---- test/tb.sv ----
// Self-checking testbench for the supply and ADC configuration register bank.
`timescale 1ns/1ps

module tb;
    localparam int         STEP = 4;
    localparam logic [7:0] SUP  = sac_pkg::IDX_SUPPLY_SETUP;
    localparam logic [7:0] ADC  = sac_pkg::IDX_ADC_SETUP;
    localparam logic [7:0] STS  = sac_pkg::IDX_ADC_STATUS;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        hready;
    logic        undervoltageRelease = 1'b0;
    logic        adcDone = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [6:0]  adcResult = 7'h00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd, d;
    logic        hreadyout, hresp, logicRailEnable, pumpPrecharge, buckRateSelect;
    logic        onDemandRequest, filterEnablePulse, onDemandFilterOn;
    logic [1:0]  onDemandSelect, averageDepth;
    logic [6:0]  averageSamples;
    int          err_total = 0;
    int          samples_checked = 0;
    int          n;
    integer      seed = 32'h2f98;

    assign hready = hreadyout;

    sac_regs #(.TON_STEP_CYCLES(STEP)) u_sac_regs (.clk, .srst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .undervoltageRelease, .adcDone,
        .adcResult, .logicRailEnable, .pumpPrecharge, .buckRateSelect, .onDemandRequest,
        .onDemandSelect, .filterEnablePulse, .onDemandFilterOn, .averageDepth, .averageSamples);

    task automatic bus(input logic w, input logic [7:0] idx, input logic [1:0] lane,
                       input logic [2:0] hs, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= sac_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= hs;
        haddr <= {22'h0, idx, lane};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [6:0] expSamples(input logic [1:0] code);
        case (code)
            2'h0: return 7'h08;
            2'h1: return 7'h10;
            2'h2: return 7'h20;
            default: return 7'h40;
        endcase
    endfunction

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        bus(1'b1, idx, 2'h0, 3'h2, wd);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 2'h0, 3'h2, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        results();
    end

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdc(SUP, 32'h0000_6000);
        rdc(ADC, 32'h0000_0000);
        rdc(8'h30, 32'h0000_0000);
        chk({buckRateSelect, pumpPrecharge, averageSamples}, 9'h008);
        chk({hresp, hreadyout}, 2'b01);
        wr(ADC, 32'h0000_0008);
        #1;
        chk({filterEnablePulse, onDemandFilterOn}, 2'b10);
        @(posedge clk);
        #1;
        chk({filterEnablePulse, onDemandFilterOn}, 2'b01);
        wr(ADC, 32'h0000_0000);
        chk(onDemandFilterOn, 1'b1);
        wr(ADC, 32'h0000_0036);
        bus(1'b1, ADC, 2'h1, sac_pkg::HSIZE_BYTE, 32'h0000_ff00);
        rdc(ADC, 32'h0000_0000);
        wr(SUP, 32'h0000_f000);
        bus(1'b1, SUP, 2'h0, sac_pkg::HSIZE_BYTE, 32'h0000_00ff);
        rdc(SUP, 32'h0000_f000);
        bus(1'b1, SUP, 2'h0, sac_pkg::HSIZE_HALF, 32'h0000_a000);
        rdc(SUP, 32'h0000_a000);
        repeat (8) begin
            d = $random(seed);
            wr(SUP, d);
            rdc(SUP, d & 32'h0000_f000);
            chk(buckRateSelect, d[12]);
            wr(ADC, d);
            rdc(ADC, d & 32'h0000_0036);
            chk({onDemandSelect, averageDepth}, {d[2:1], d[5:4]});
            chk(averageSamples, expSamples(d[5:4]));
        end
        for (int s = 0; s < 4; s++) begin
            wr(ADC, {29'h0, s[1:0], 1'b1});
            #1;
            chk({onDemandRequest, onDemandSelect}, {s != 3, s[1:0]});
            @(posedge clk);
            #1;
            chk(onDemandRequest, 1'b0);
        end
        d = $random(seed);
        adcResult <= d[6:0];
        adcDone <= 1'b1;
        @(posedge clk);
        adcDone <= 1'b0;
        rdc(STS, {24'h0, d[6:0], 1'b1});
        bus(1'b0, STS, 2'h0, 3'h2, 32'h0000_0000);
        chk(rd[0], 1'b0);
        // A completion in the same cycle as a status read must keep ready set.
        fork
            bus(1'b0, STS, 2'h0, 3'h2, 32'h0000_0000);
            begin
                adcDone <= 1'b1;
                @(posedge clk);
                adcDone <= 1'b0;
            end
        join
        chk(rd[0], 1'b0);
        rdc(STS, {24'h0, d[6:0], 1'b1});
        for (int c = 0; c < 4; c++) begin
            wr(SUP, {16'h0, c[0], c[1:0], 13'h0});
            undervoltageRelease <= 1'b1;
            n = 0;
            while (logicRailEnable !== 1'b1 && n < 100) begin
                @(posedge clk);
                #1;
                n++;
                if (n == 2) chk(pumpPrecharge, c[0]);
            end
            chk(n, (c + 1) * STEP + 1);
            undervoltageRelease <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            chk(logicRailEnable, 1'b0);
        end
        // A second reset in mid-run must clear the sticky filter and restore defaults.
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk({onDemandFilterOn, logicRailEnable, averageSamples}, 9'h008);
        rdc(SUP, 32'h0000_6000);
        rdc(ADC, 32'h0000_0000);
        results();
    end
endmodule
